// file: hdl/cpts_pkg.sv
// package of register map, field positions and carrier types for the priority and trap status block
package cpts_pkg;
  localparam int unsigned addr_width = 8;
  localparam logic [7:0] core_control_offset = 8'h00;
  localparam logic [7:0] interrupt_control_one_offset = 8'h04;
  localparam logic [7:0] cpu_status_word_offset = 8'h08;
  localparam int unsigned priority_top_bit_pos = 3;
  localparam int unsigned priority_low_lsb = 5;
  localparam int unsigned priority_low_msb = 7;
  localparam int unsigned nesting_disable_pos = 15;
  localparam int unsigned acc_a_overflow_pos = 14;
  localparam int unsigned acc_b_overflow_pos = 13;
  localparam logic [3:0] priority_user_ceiling = 4'h7;
  localparam logic [2:0] priority_low_reset = 3'h0;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } cpts_apb_req_type;

  typedef struct packed {
    logic set_top;
    logic acc_a_overflow;
    logic acc_b_overflow;
  } cpts_trap_event_type;
endpackage : cpts_pkg

// file: hdl/cpts_sticky_flag.sv
// one sticky event flag: hardware sets, software clears by writing zero
`timescale 1ns/100ps
`default_nettype none
module cpts_sticky_flag (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // event and software access
  input wire logic set_in,
  input wire logic write_in,
  input wire logic wdata_in,
  // state
  output logic flag_out
);
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1; // set wins over a clear in the same cycle
    end else if (write_in && !wdata_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule : cpts_sticky_flag
`default_nettype wire

// file: hdl/cpts_top.sv
// cpu priority level top bit, nesting disable and accumulator overflow trap flags over apb
`timescale 1ns/100ps
`default_nettype none
module cpts_top (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // core and trap sources, same clock
  input wire cpts_pkg::cpts_trap_event_type trap_event_in,
  input wire logic core_low_write_in,
  input wire logic [2:0] core_low_data_in,
  // status to the core and the arbiter
  output logic [3:0] cpu_priority_level_out,
  output logic user_irq_block_out,
  output logic nesting_disable_out
);
  cpts_pkg::cpts_apb_req_type req;
  logic priority_top_bit;
  logic [2:0] priority_low_bits;
  logic nesting_disable;
  logic acc_a_overflow_trap_flag;
  logic acc_b_overflow_trap_flag;
  logic access;
  logic wr_core;
  logic wr_intc;
  logic wr_status;
  logic mapped;
  logic [3:0] next_level;
  logic [31:0] next_rdata;

  // decode strobes and read images
  logic sel_core;
  logic sel_intc;
  logic sel_status;
  logic rd_take;
  logic next_top_bit;
  logic [2:0] next_low_bits;
  logic [31:0] core_control_word;
  logic [31:0] interrupt_control_one_word;
  logic [31:0] cpu_status_word;
  // trap flags, entry 1 at bit 14, entry 0 at bit 13
  localparam int unsigned trap_flag_count = 2;
  logic [trap_flag_count-1:0] trap_flag_set;
  logic [trap_flag_count-1:0] trap_flag_wdata;
  logic [trap_flag_count-1:0] trap_flags;

  assign req = '{paddr: paddr_in, psel: psel_in, penable: penable_in, pwrite: pwrite_in, pwdata: pwdata_in};
  // two-cycle access phase: pready raised in the cycle after the first penable cycle
  assign access = req.psel && req.penable && !pready_out;
  assign sel_core = (req.paddr == cpts_pkg::core_control_offset);
  assign sel_intc = (req.paddr == cpts_pkg::interrupt_control_one_offset);
  assign sel_status = (req.paddr == cpts_pkg::cpu_status_word_offset);
  assign mapped = sel_core || sel_intc || sel_status;
  assign wr_core = access && req.pwrite && sel_core;
  assign wr_intc = access && req.pwrite && sel_intc;
  assign wr_status = access && req.pwrite && sel_status;
  assign rd_take = access && !req.pwrite;

  // top bit: raised only by trap entry, software may only clear it
  always_comb begin
    next_top_bit = priority_top_bit;
    if (trap_event_in.set_top) begin
      next_top_bit = 1'b1; // set wins over a clearing write in the same cycle
    end else if (wr_core && !req.pwdata[cpts_pkg::priority_top_bit_pos]) begin
      next_top_bit = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      priority_top_bit <= 1'b0;
    end else begin
      priority_top_bit <= next_top_bit;
    end
  end

  // low bits: frozen for software while nesting is disabled, core still updates them
  always_comb begin
    next_low_bits = priority_low_bits;
    if (core_low_write_in) begin
      next_low_bits = core_low_data_in;
    end else if (wr_status && !nesting_disable) begin
      next_low_bits = req.pwdata[cpts_pkg::priority_low_msb:cpts_pkg::priority_low_lsb];
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      priority_low_bits <= cpts_pkg::priority_low_reset;
    end else begin
      priority_low_bits <= next_low_bits;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      nesting_disable <= 1'b0;
    end else if (wr_intc) begin
      nesting_disable <= req.pwdata[cpts_pkg::nesting_disable_pos];
    end
  end

  assign trap_flag_set = {trap_event_in.acc_a_overflow, trap_event_in.acc_b_overflow};
  assign trap_flag_wdata = req.pwdata[cpts_pkg::acc_a_overflow_pos:cpts_pkg::acc_b_overflow_pos];
  for (genvar gi = 0; gi < trap_flag_count; gi++) begin : g_trap_flag
    cpts_sticky_flag u_flag (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .set_in(trap_flag_set[gi]),
      .write_in(wr_intc),
      .wdata_in(trap_flag_wdata[gi]),
      .flag_out(trap_flags[gi])
    );
  end
  assign acc_a_overflow_trap_flag = trap_flags[1];
  assign acc_b_overflow_trap_flag = trap_flags[0];

  // outputs follow the stored state one cycle later to stay registered
  assign next_level = {priority_top_bit, priority_low_bits};
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cpu_priority_level_out <= 4'h0;
    end else begin
      cpu_priority_level_out <= next_level;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      user_irq_block_out <= 1'b0;
    end else begin
      user_irq_block_out <= priority_top_bit;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      nesting_disable_out <= 1'b0;
    end else begin
      nesting_disable_out <= nesting_disable;
    end
  end

  // register images, unimplemented bits read zero
  always_comb begin
    core_control_word = 32'h0000_0000;
    core_control_word[cpts_pkg::priority_top_bit_pos] = priority_top_bit;
  end

  always_comb begin
    interrupt_control_one_word = 32'h0000_0000;
    interrupt_control_one_word[cpts_pkg::nesting_disable_pos] = nesting_disable;
    interrupt_control_one_word[cpts_pkg::acc_a_overflow_pos] = acc_a_overflow_trap_flag;
    interrupt_control_one_word[cpts_pkg::acc_b_overflow_pos] = acc_b_overflow_trap_flag;
  end

  always_comb begin
    cpu_status_word = 32'h0000_0000;
    cpu_status_word[cpts_pkg::priority_low_msb:cpts_pkg::priority_low_lsb] = priority_low_bits;
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (req.paddr)
      cpts_pkg::core_control_offset: begin
        next_rdata = core_control_word;
      end
      cpts_pkg::interrupt_control_one_offset: begin
        next_rdata = interrupt_control_one_word;
      end
      cpts_pkg::cpu_status_word_offset: begin
        next_rdata = cpu_status_word;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // pready gates access, so a penable still high in the pready cycle cannot write twice
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= access;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= access && !mapped;
    end
  end

  // read data holds between reads, writes leave it alone
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (rd_take) begin
      prdata_out <= next_rdata;
    end
  end
endmodule : cpts_top
`default_nettype wire

// file: sim/cpts_core_model.sv
// behavioural core and trap sources
`timescale 1ns/100ps
`default_nettype none
module cpts_core_model (
  // clock
  input wire logic clock_in,
  // towards the block
  output logic [2:0] trap_event_out,
  output logic core_low_write_out,
  output logic [2:0] core_low_data_out
);
  initial {trap_event_out, core_low_write_out, core_low_data_out} = 7'h00;
  // one-cycle pulses; load data scrambled once released
  task automatic pulse(input logic [2:0] ev, input logic wr, input logic [2:0] d);
    @(posedge clock_in);
    {trap_event_out, core_low_write_out, core_low_data_out} <= {ev, wr, d};
    @(posedge clock_in);
    {trap_event_out, core_low_write_out, core_low_data_out} <= {4'h0, ~d};
  endtask : pulse
endmodule : cpts_core_model
`default_nettype wire

// file: sim/cpts_top_assertions.sv
// concurrent checks on level, nesting and apb answer
`timescale 1ns/100ps
`default_nettype none
module cpts_top_assertions (
  // watched ports
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire cpts_pkg::cpts_trap_event_type trap_event_in,
  input wire logic core_low_write_in,
  input wire logic [2:0] core_low_data_in,
  input wire logic [3:0] cpu_priority_level_out,
  input wire logic user_irq_block_out,
  input wire logic nesting_disable_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire logic take = psel_in && penable_in && !pready_out;
  wire logic wr = take && pwrite_in;
  wire logic [3:0] lvl = cpu_priority_level_out;
  // core loads around the write would hide a wrongly taken write
  sequence frozen_try;
    !core_low_write_in ##1 (wr && paddr_in == 8'h08 && nesting_disable_out && !core_low_write_in) ##1 !core_low_write_in;
  endsequence
  a_block_top: assert property (user_irq_block_out == lvl[3]) else $error("block");
  a_top_event: assert property (trap_event_in.set_top |=> ##1 lvl[3]) else $error("top set");
  a_top_rise: assert property ($rose(lvl[3]) |-> $past(trap_event_in.set_top, 2)) else $error("top rise");
  a_top_fall: assert property ($fell(lvl[3]) |-> $past(wr && paddr_in == 8'h00, 2)) else $error("top fall");
  a_nest_write: assert property (wr && paddr_in == 8'h04 |=> ##1 nesting_disable_out == $past(pwdata_in[15], 2))
    else $error("nest");
  a_core_load: assert property (core_low_write_in |=> ##1 lvl[2:0] == $past(core_low_data_in, 2))
    else $error("load");
  a_low_frozen: assert property (frozen_try |=> lvl[2:0] == $past(lvl[2:0], 2)) else $error("frozen");
  a_answer_next: assert property (take |=> pready_out) else $error("ready");
endmodule : cpts_top_assertions
bind cpts_top cpts_top_assertions chk (.*);
`default_nettype wire

// file: sim/cpts_top_tb.sv
// bench: reset, top bit, trap flags, nesting freeze, unmapped access
`timescale 1ns/100ps
`default_nettype none
module cpts_top_tb;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  cpts_pkg::cpts_apb_req_type req = '0;
  cpts_pkg::cpts_trap_event_type ev;
  logic [31:0] rd, r;
  logic [3:0] lvl;
  logic [2:0] cd;
  logic cw, rdy, err, blk, nst, e;
  int fail_count = 0;
  int cmp_count = 0;
  always #12.5 clock_in = ~clock_in;
  cpts_top uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .paddr_in(req.paddr), .psel_in(req.psel),
    .penable_in(req.penable), .pwrite_in(req.pwrite), .pwdata_in(req.pwdata), .prdata_out(rd),
    .pready_out(rdy), .pslverr_out(err), .trap_event_in(ev), .core_low_write_in(cw), .core_low_data_in(cd),
    .cpu_priority_level_out(lvl), .user_irq_block_out(blk), .nesting_disable_out(nst));
  cpts_core_model core (.clock_in(clock_in), .trap_event_out(ev), .core_low_write_out(cw),
    .core_low_data_out(cd));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clock_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t apb answer timeout", $time);
      summarize();
    end else begin
      r = rd;
      e = err;
      req <= '0;
    end
  endtask : xfer
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    xfer(a, 1'b0, 32'h0);
    chk(r, exp, m);
  endtask : rdc
  task automatic t_top();
    rdc(8'h00, 32'h0, "core rst");
    rdc(8'h04, 32'h0, "ctl rst");
    xfer(8'h00, 1'b1, 32'h8);
    rdc(8'h00, 32'h0, "top by write");
    core.pulse(3'h4, 1'b0, 3'h0);
    rdc(8'h00, 32'h8, "top by trap");
    chk({27'h0, blk, lvl}, 32'h18, "block level");
    xfer(8'h00, 1'b1, 32'h0);
    rdc(8'h00, 32'h0, "top clear");
    chk({27'h0, blk, lvl}, 32'h0, "unblocked");
    $display("top end");
  endtask : t_top
  task automatic t_flags();
    core.pulse(3'h2, 1'b0, 3'h0);
    rdc(8'h04, 32'h4000, "acc a");
    core.pulse(3'h1, 1'b0, 3'h0);
    xfer(8'h04, 1'b1, 32'h6000);
    rdc(8'h04, 32'h6000, "acc b held");
    xfer(8'h04, 1'b1, 32'h0);
    rdc(8'h04, 32'h0, "flags clear");
    $display("flags end");
  endtask : t_flags
  task automatic t_nest();
    xfer(8'h04, 1'b1, 32'h8000);
    rdc(8'h04, 32'h8000, "nest set");
    xfer(8'h08, 1'b1, 32'hE0);
    rdc(8'h08, 32'h0, "frozen");
    core.pulse(3'h0, 1'b1, 3'h5);
    rdc(8'h08, 32'hA0, "core load");
    xfer(8'h04, 1'b1, 32'h0);
    xfer(8'h08, 1'b1, 32'hE0);
    rdc(8'h08, 32'hE0, "low write");
    chk({27'h0, nst, lvl}, 32'h7, "level");
    xfer(8'h0C, 1'b0, 32'h0);
    chk({r[31:1], e}, 32'h1, "unmapped");
    $display("nest end");
  endtask : t_nest
  initial begin
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_top();
    t_flags();
    t_nest();
    summarize();
  end
endmodule : cpts_top_tb
`default_nettype wire
